// file: hw/ppd_core.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - program space uses a 12-bit counter; bit 11 picks the static page
// - four 2K pages; lower half shows the page chosen by page select
// - counter bit 11 set maps fetch to page 1 regardless of page select
// - page select one in lower half reaches the same static storage
// - with bit 11 clear, select 00..11 picks pages 0..3
// - page select at CAh, byte write only; reads and bit ops unsupported
// - page select content is undefined to software after reset
// - page select untouched by interrupts, calls and returns
// - static page holds vectors and stays reachable at all times
// - readout protection blocks external reads of program memory
// - 64-byte read-only window at 40h..7Fh reads program memory
// - 00h..3Fh banked onto two RAM and two EEPROM 64-byte banks
// - six-entry 12-bit return stack
// - 60 bytes general RAM beside core and peripheral registers
// - window address is window register over six low address bits
// - bank select one hot: bits 0,1 EEPROM, bits 3,4 RAM pages
module ppd_core (
  input  wire logic                        clk_i,
  input  wire logic                        resetn_i,
  input  wire logic                        ce_i,
  input  wire logic                        fetch_i,
  input  wire logic [ppd_pkg::PC_W-1:0]    pc_i,
  output logic      [ppd_pkg::PHYS_W-1:0]  fetch_addr_o,
  output logic                             fetch_valid_o,
  input  wire logic                        data_rd_i,
  input  wire logic                        data_wr_i,
  input  wire logic                        data_bitop_i,
  input  wire logic [ppd_pkg::ADDR_W-1:0]  data_addr_i,
  input  wire logic [ppd_pkg::DATA_W-1:0]  data_wdata_i,
  output logic      [ppd_pkg::DATA_W-1:0]  data_rdata_o,
  output logic                             data_rvalid_o,
  output logic      [ppd_pkg::PHYS_W-1:0]  mem_addr_o,
  input  wire logic [ppd_pkg::DATA_W-1:0]  mem_data_i,
  input  wire logic                        readout_protect_i,
  input  wire logic                        ext_rd_i,
  input  wire logic [ppd_pkg::PHYS_W-1:0]  ext_addr_i,
  output logic                             ext_ready_o,
  output logic      [ppd_pkg::DATA_W-1:0]  ext_data_o,
  output logic                             ext_valid_o,
  output logic                             ext_denied_o,
  output logic                             eeprom_req_o,
  output logic                             eeprom_wr_o,
  output logic                             eeprom_page_o,
  output logic      [ppd_pkg::WIN_LOW_W-1:0] eeprom_addr_o,
  output logic      [ppd_pkg::DATA_W-1:0]  eeprom_wdata_o,
  input  wire logic [ppd_pkg::DATA_W-1:0]  eeprom_rdata_i,
  output logic                             periph_req_o,
  output logic                             periph_wr_o,
  output logic      [ppd_pkg::ADDR_W-1:0]  periph_addr_o,
  output logic      [ppd_pkg::DATA_W-1:0]  periph_wdata_o,
  input  wire logic [ppd_pkg::DATA_W-1:0]  periph_rdata_i,
  input  wire logic                        push_i,
  input  wire logic                        pop_i,
  input  wire logic [ppd_pkg::PC_W-1:0]    push_data_i,
  output logic      [ppd_pkg::PC_W-1:0]    stack_top_o,
  output logic      [ppd_pkg::CNT_W-1:0]   stack_depth_o
);
  import ppd_pkg::*;

  // physical program address for a counter value and page select
  function automatic logic [PHYS_W-1:0] map_fetch(
    input logic [PC_W-1:0]   pc,
    input logic [PAGE_W-1:0] sel
  );
    logic [PAGE_W-1:0] page;
    page = pc[PC_MSB] ? STATIC_PAGE : sel;
    // page 1 through either half lands on one physical 2K
    return {page, pc[OFS_W-1:0]};
  endfunction : map_fetch

  // data-space region of an address under the current bank select
  function automatic ppd_region_type decode(
    input logic [ADDR_W-1:0] addr,
    input logic [7:0]        bank
  );
    ppd_region_type r;
    r = RG_PERIPH;
    if (addr <= BANK_HI) begin
      unique case (bank)
        BANK_EE0:  r = RG_EE0;
        BANK_EE1:  r = RG_EE1;
        BANK_RAM1: r = RG_BRAM1;
        BANK_RAM2: r = RG_BRAM2;
        default:   r = RG_BANK_NONE;
      endcase
    end else if (addr <= WIN_HI) begin
      r = RG_WINDOW;
    end else if ((addr >= RAM_LO) && (addr <= RAM_HI)) begin
      r = RG_RAM;
    end else if (addr == PAGE_REG) begin
      r = RG_PAGE_REG;
    end else if (addr == WINDOW_REG) begin
      r = RG_WINDOW_REG;
    end else if (addr == BANK_REG) begin
      r = RG_BANK_REG;
    end
    return r;
  endfunction : decode

  logic [PAGE_W-1:0]    page_sel_reg, page_sel_next;
  logic [WIN_REG_W-1:0] win_pos_reg,  win_pos_next;
  logic [7:0]           bank_sel_reg, bank_sel_next;
  logic [PHYS_W-1:0]    fetch_addr_reg, fetch_addr_next;
  logic                 fetch_valid_reg, fetch_valid_next;
  logic                 s1_valid_reg, s1_valid_next;
  logic                 s1_rd_reg,    s1_rd_next;
  ppd_region_type       s1_region_reg, s1_region_next;
  logic [ADDR_W-1:0]    s1_addr_reg,  s1_addr_next;
  logic [DATA_W-1:0]    s1_wdata_reg, s1_wdata_next;
  logic [PHYS_W-1:0]    mem_addr_reg, mem_addr_next;
  logic                 mem_ext_reg,  mem_ext_next;
  logic [DATA_W-1:0]    rdata_reg,    rdata_next;
  logic                 rvalid_reg,   rvalid_next;
  logic [DATA_W-1:0]    ext_data_reg, ext_data_next;
  logic                 ext_valid_reg, ext_valid_next;
  logic                 ext_denied_reg, ext_denied_next;

  ppd_region_type    region;
  logic              win_rd;
  logic              ram_we;
  logic              bank_we;
  logic [RAM_AW-1:0] ram_waddr;
  logic [RAM_AW-1:0] ram_raddr;
  logic [DATA_W-1:0] ram_rdata;
  logic [DATA_W-1:0] bank_rdata;

  assign region  = decode(data_addr_i, bank_sel_reg);
  assign win_rd  = data_rd_i && (region == RG_WINDOW);
  assign ram_we  = data_wr_i && (region == RG_RAM);
  assign bank_we = data_wr_i &&
                   ((region == RG_BRAM1) || (region == RG_BRAM2));
  assign ram_waddr = RAM_AW'(data_addr_i - RAM_LO);
  assign ram_raddr = RAM_AW'(s1_addr_reg - RAM_LO);
  // core window reads win the shared program memory port
  assign ext_ready_o = !win_rd;

  // write-only control registers
  always_comb begin
    page_sel_next = page_sel_reg;
    win_pos_next  = win_pos_reg;
    bank_sel_next = bank_sel_reg;
    // bit operations on write-only registers are dropped
    if (data_wr_i && !data_bitop_i) begin
      unique case (region)
        RG_PAGE_REG: begin
          page_sel_next = {data_wdata_i[PAGE_HIGH_BIT],
                           data_wdata_i[PAGE_LOW_BIT]};
        end
        RG_WINDOW_REG: win_pos_next  = data_wdata_i[WIN_REG_W-1:0];
        RG_BANK_REG:   bank_sel_next = data_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // only a data write changes page select; stack traffic never does
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      page_sel_reg <= PAGE_RESET;
      win_pos_reg  <= WINDOW_RESET;
      bank_sel_reg <= BANK_RESET;
    end else if (ce_i) begin
      page_sel_reg <= page_sel_next;
      win_pos_reg  <= win_pos_next;
      bank_sel_reg <= bank_sel_next;
    end
  end

  // fetch path and first access stage
  always_comb begin
    fetch_valid_next = fetch_i;
    fetch_addr_next  = fetch_addr_reg;
    if (fetch_i) begin
      fetch_addr_next = map_fetch(pc_i, page_sel_reg);
    end
    s1_valid_next  = data_rd_i || data_wr_i;
    s1_rd_next     = data_rd_i;
    s1_region_next = region;
    s1_addr_next   = data_addr_i;
    s1_wdata_next  = data_wdata_i;
    mem_addr_next  = mem_addr_reg;
    mem_ext_next   = 1'b0;
    if (win_rd) begin
      mem_addr_next = {win_pos_reg, data_addr_i[WIN_LOW_W-1:0]};
    end else if (ext_rd_i) begin
      mem_addr_next = ext_addr_i;
      mem_ext_next  = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fetch_addr_reg  <= '0;
      fetch_valid_reg <= 1'b0;
      s1_valid_reg    <= 1'b0;
      s1_rd_reg       <= 1'b0;
      s1_region_reg   <= RG_BANK_NONE;
      s1_addr_reg     <= '0;
      s1_wdata_reg    <= '0;
      mem_addr_reg    <= '0;
      mem_ext_reg     <= 1'b0;
    end else if (ce_i) begin
      fetch_addr_reg  <= fetch_addr_next;
      fetch_valid_reg <= fetch_valid_next;
      s1_valid_reg    <= s1_valid_next;
      s1_rd_reg       <= s1_rd_next;
      s1_region_reg   <= s1_region_next;
      s1_addr_reg     <= s1_addr_next;
      s1_wdata_reg    <= s1_wdata_next;
      mem_addr_reg    <= mem_addr_next;
      mem_ext_reg     <= mem_ext_next;
    end
  end

  // second stage: read data return
  always_comb begin
    rvalid_next = s1_valid_reg && s1_rd_reg;
    rdata_next  = rdata_reg;
    if (rvalid_next) begin
      unique case (s1_region_reg)
        RG_RAM:              rdata_next = ram_rdata;
        RG_BRAM1, RG_BRAM2:  rdata_next = bank_rdata;
        RG_EE0, RG_EE1:      rdata_next = eeprom_rdata_i;
        RG_WINDOW:           rdata_next = mem_data_i;
        RG_PERIPH:           rdata_next = periph_rdata_i;
        default:             rdata_next = UNREAD_VALUE;
      endcase
    end
    ext_valid_next  = mem_ext_reg;
    ext_denied_next = mem_ext_reg && readout_protect_i;
    ext_data_next   = ext_data_reg;
    if (mem_ext_reg) begin
      ext_data_next = readout_protect_i ? UNREAD_VALUE
                                        : mem_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg      <= '0;
      rvalid_reg     <= 1'b0;
      ext_data_reg   <= '0;
      ext_valid_reg  <= 1'b0;
      ext_denied_reg <= 1'b0;
    end else if (ce_i) begin
      rdata_reg      <= rdata_next;
      rvalid_reg     <= rvalid_next;
      ext_data_reg   <= ext_data_next;
      ext_valid_reg  <= ext_valid_next;
      ext_denied_reg <= ext_denied_next;
    end
  end

  ppd_ram #(.DEPTH(RAM_DEPTH), .AW(RAM_AW)) u_gen_ram (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .we_i     (ram_we),
    .waddr_i  (ram_waddr),
    .wdata_i  (data_wdata_i),
    .raddr_i  (ram_raddr),
    .rdata_o  (ram_rdata)
  );

  ppd_ram #(.DEPTH(BANK_DEPTH), .AW(BANK_AW)) u_bank_ram (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .we_i     (bank_we),
    .waddr_i  ({region == RG_BRAM2, data_addr_i[WIN_LOW_W-1:0]}),
    .wdata_i  (data_wdata_i),
    .raddr_i  ({s1_region_reg == RG_BRAM2, s1_addr_reg[WIN_LOW_W-1:0]}),
    .rdata_o  (bank_rdata)
  );

  ppd_stack u_stack (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .ce_i        (ce_i),
    .push_i      (push_i),
    .pop_i       (pop_i),
    .push_data_i (push_data_i),
    .top_o       (stack_top_o),
    .depth_o     (stack_depth_o)
  );

  assign fetch_addr_o   = fetch_addr_reg;
  assign fetch_valid_o  = fetch_valid_reg;
  assign data_rdata_o   = rdata_reg;
  assign data_rvalid_o  = rvalid_reg;
  assign mem_addr_o     = mem_addr_reg;
  assign ext_data_o     = ext_data_reg;
  assign ext_valid_o    = ext_valid_reg;
  assign ext_denied_o   = ext_denied_reg;
  assign eeprom_req_o   = s1_valid_reg &&
                          ((s1_region_reg == RG_EE0) ||
                           (s1_region_reg == RG_EE1));
  assign eeprom_wr_o    = eeprom_req_o && !s1_rd_reg;
  assign eeprom_page_o  = (s1_region_reg == RG_EE1);
  assign eeprom_addr_o  = s1_addr_reg[WIN_LOW_W-1:0];
  assign eeprom_wdata_o = s1_wdata_reg;
  assign periph_req_o   = s1_valid_reg && (s1_region_reg == RG_PERIPH);
  assign periph_wr_o    = periph_req_o && !s1_rd_reg;
  assign periph_addr_o  = s1_addr_reg;
  assign periph_wdata_o = s1_wdata_reg;
endmodule : ppd_core
`default_nettype wire

// file: hw/ppd_pkg.sv
`default_nettype none
package ppd_pkg;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 8;
  localparam int PC_W        = 12;
  localparam int PHYS_W      = 13;
  localparam int PAGE_W      = 2;
  localparam int OFS_W       = 11;
  localparam int WIN_LOW_W   = 6;
  localparam int WIN_REG_W   = 7;
  localparam int STACK_DEPTH = 6;
  localparam int CNT_W       = 3;
  localparam int RAM_DEPTH   = 60;
  localparam int RAM_AW      = 6;
  localparam int BANK_DEPTH  = 128;
  localparam int BANK_AW     = 7;

  // data-space map
  localparam logic [7:0] BANK_LO     = 8'h00;
  localparam logic [7:0] BANK_HI     = 8'h3f;
  localparam logic [7:0] WIN_LO      = 8'h40;
  localparam logic [7:0] WIN_HI      = 8'h7f;
  localparam logic [7:0] RAM_LO      = 8'h84;
  localparam logic [7:0] RAM_HI      = 8'hbf;
  localparam logic [7:0] WINDOW_REG  = 8'hc9;
  localparam logic [7:0] PAGE_REG    = 8'hca;
  localparam logic [7:0] BANK_REG    = 8'hcb;

  // page select fields
  localparam int PAGE_LOW_BIT  = 0;
  localparam int PAGE_HIGH_BIT = 1;
  localparam int PC_MSB        = 11;
  localparam logic [PAGE_W-1:0] STATIC_PAGE = 2'h1;

  // bank select codes, one hot
  localparam logic [7:0] BANK_EE0  = 8'h01;
  localparam logic [7:0] BANK_EE1  = 8'h02;
  localparam logic [7:0] BANK_RAM1 = 8'h08;
  localparam logic [7:0] BANK_RAM2 = 8'h10;

  // reset values
  localparam logic [PAGE_W-1:0]    PAGE_RESET   = 2'h0;
  localparam logic [WIN_REG_W-1:0] WINDOW_RESET = 7'h00;
  localparam logic [7:0]           BANK_RESET   = 8'h00;
  localparam logic [7:0]           UNREAD_VALUE = 8'h00;

  // vectors inside the static page
  localparam logic [PC_W-1:0] RESET_VECTOR = 12'hffe;
  localparam logic [PC_W-1:0] NMI_VECTOR   = 12'hffc;

  typedef enum logic [3:0] {
    RG_BANK_NONE, RG_EE0, RG_EE1, RG_BRAM1, RG_BRAM2, RG_WINDOW,
    RG_RAM, RG_PAGE_REG, RG_WINDOW_REG, RG_BANK_REG, RG_PERIPH
  } ppd_region_type;
endpackage : ppd_pkg
`default_nettype wire

// file: hw/ppd_ram.sv
`timescale 1ns/1ps
`default_nettype none
module ppd_ram #(
  parameter int DEPTH = 60,
  parameter int AW    = 6
) (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  ce_i,
  input  wire logic                  we_i,
  input  wire logic [AW-1:0]         waddr_i,
  input  wire logic [ppd_pkg::DATA_W-1:0] wdata_i,
  input  wire logic [AW-1:0]         raddr_i,
  output logic      [ppd_pkg::DATA_W-1:0] rdata_o
);
  import ppd_pkg::*;

  logic [DATA_W-1:0] mem_reg  [DEPTH];
  logic [DATA_W-1:0] mem_next [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_word
      always_comb begin
        mem_next[g] = mem_reg[g];
        if (we_i && (waddr_i == AW'(g))) begin
          mem_next[g] = wdata_i;
        end
      end
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          mem_reg[g] <= '0;
        end else if (ce_i) begin
          mem_reg[g] <= mem_next[g];
        end
      end
    end
  endgenerate

  // out-of-range index reads as zero
  assign rdata_o = (int'(raddr_i) < DEPTH) ? mem_reg[raddr_i] : '0;
endmodule : ppd_ram
`default_nettype wire

// file: hw/ppd_stack.sv
`timescale 1ns/1ps
`default_nettype none
module ppd_stack (
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  input  wire logic                    ce_i,
  input  wire logic                    push_i,
  input  wire logic                    pop_i,
  input  wire logic [ppd_pkg::PC_W-1:0] push_data_i,
  output logic      [ppd_pkg::PC_W-1:0] top_o,
  output logic      [ppd_pkg::CNT_W-1:0] depth_o
);
  import ppd_pkg::*;

  logic [PC_W-1:0]  ent_reg  [STACK_DEPTH];
  logic [PC_W-1:0]  ent_next [STACK_DEPTH];
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  genvar g;
  generate
    for (g = 0; g < STACK_DEPTH; g++) begin : g_ent
      always_comb begin
        ent_next[g] = ent_reg[g];
        if (push_i && pop_i) begin
          if (g == 0) ent_next[g] = push_data_i;
        end else if (push_i) begin
          // deepest entry falls off on overflow
          ent_next[g] = (g == 0) ? push_data_i : ent_reg[(g == 0) ? 0 : g-1];
        end else if (pop_i) begin
          ent_next[g] = ent_reg[(g == STACK_DEPTH-1) ? g : g+1];
        end
      end
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          ent_reg[g] <= '0;
        end else if (ce_i) begin
          ent_reg[g] <= ent_next[g];
        end
      end
    end
  endgenerate

  always_comb begin
    cnt_next = cnt_reg;
    if (push_i && !pop_i && (cnt_reg != CNT_W'(STACK_DEPTH))) begin
      cnt_next = cnt_reg + 3'h1;
    end else if (pop_i && !push_i && (cnt_reg != 3'h0)) begin
      cnt_next = cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= '0;
    end else if (ce_i) begin
      cnt_reg <= cnt_next;
    end
  end

  assign top_o   = ent_reg[0];
  assign depth_o = cnt_reg;
endmodule : ppd_stack
`default_nettype wire

// file: tb/ppd_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ppd_core_chk
  import ppd_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              resetn_i,
  input wire logic              ce_i,
  input wire logic              fetch_i,
  input wire logic [PC_W-1:0]   pc_i,
  input wire logic [PHYS_W-1:0] fetch_addr_o,
  input wire logic              fetch_valid_o,
  input wire logic              data_rd_i,
  input wire logic [ADDR_W-1:0] data_addr_i,
  input wire logic              data_rvalid_o,
  input wire logic [PHYS_W-1:0] mem_addr_o,
  input wire logic              readout_protect_i,
  input wire logic              ext_rd_i,
  input wire logic              ext_ready_o,
  input wire logic [DATA_W-1:0] ext_data_o,
  input wire logic              ext_valid_o,
  input wire logic              ext_denied_o,
  input wire logic              push_i,
  input wire logic              pop_i,
  input wire logic [CNT_W-1:0]  stack_depth_o
);
  logic f_tk;
  logic r_tk;
  logic win;
  assign f_tk = ce_i && fetch_i;
  assign r_tk = ce_i && data_rd_i;
  assign win = data_addr_i >= WIN_LO && data_addr_i <= WIN_HI;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  chk_fetch_pulse: assert property (f_tk |=> fetch_valid_o)
    else $error("fetch answer missing");
  chk_fetch_idle: assert property (!f_tk |=> !fetch_valid_o)
    else $error("fetch answer without request");
  chk_fetch_static: assert property (f_tk && pc_i[PC_MSB] |=>
    fetch_addr_o == {STATIC_PAGE, $past(pc_i[OFS_W-1:0])})
    else $error("static page fetch mapped wrongly");
  chk_fetch_offset: assert property (f_tk |=>
    fetch_addr_o[OFS_W-1:0] == $past(pc_i[OFS_W-1:0]))
    else $error("fetch offset wrong");
  chk_read_latency: assert property (r_tk |-> ##2 data_rvalid_o)
    else $error("read answer not after two cycles");
  chk_window_addr: assert property (r_tk && win |=>
    mem_addr_o[WIN_LOW_W-1:0] == $past(data_addr_i[WIN_LOW_W-1:0]))
    else $error("window low address bits wrong");
  chk_window_port: assert property (r_tk && win |-> !ext_ready_o)
    else $error("window read left memory port free");
  chk_ext_deny: assert property (ext_rd_i && ext_ready_o &&
    ce_i && readout_protect_i |-> ##2
    ext_valid_o && ext_denied_o && ext_data_o == 8'h00)
    else $error("protected read not blocked");
  chk_stack_max: assert property (stack_depth_o <= 3'h6)
    else $error("stack deeper than six");
  chk_stack_push: assert property (ce_i && push_i && !pop_i &&
    stack_depth_o < 3'h6 |=> stack_depth_o == $past(stack_depth_o) + 3'h1)
    else $error("push did not deepen stack");

  cover property (f_tk && pc_i[PC_MSB]);
  cover property (r_tk && win);
  cover property (ext_valid_o && ext_denied_o);
endmodule : ppd_core_chk

bind ppd_core ppd_core_chk u_chk (.clk_i, .resetn_i, .ce_i, .fetch_i, .pc_i,
  .fetch_addr_o, .fetch_valid_o, .data_rd_i, .data_addr_i, .data_rvalid_o,
  .mem_addr_o, .readout_protect_i, .ext_rd_i, .ext_ready_o, .ext_data_o,
  .ext_valid_o, .ext_denied_o, .push_i, .pop_i, .stack_depth_o);
`default_nettype wire

// file: tb/ppd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppd_mem_model (
  input  wire logic [12:0] addr_i,
  output logic      [7:0]  data_o,
  input  wire logic        ee_req_i,
  input  wire logic        ee_page_i,
  input  wire logic [5:0]  ee_addr_i,
  output logic      [7:0]  ee_data_o,
  input  wire logic        pr_req_i,
  input  wire logic [7:0]  pr_addr_i,
  output logic      [7:0]  pr_data_o
);
  // program memory answers combinationally
  assign data_o = addr_i[7:0] ^ {3'h0, addr_i[12:8]};
  // unselected lines show the inverse, never a stale value
  assign ee_data_o = ee_req_i ? {1'b1, ee_page_i, ee_addr_i}
                              : ~{1'b1, ee_page_i, ee_addr_i};
  assign pr_data_o = pr_req_i ? pr_addr_i ^ 8'h3c : ~(pr_addr_i ^ 8'h3c);
endmodule : ppd_mem_model
`default_nettype wire

// file: tb/test_ppd_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_ppd_core;
  import ppd_pkg::*;
  typedef struct packed {
    logic [7:0]  v;
    logic [11:0] pc;
    logic [12:0] ex;
  } ppd_row_type;
  logic        clk_i, resetn_i, ce_i, fetch_i, fetch_valid_o;
  logic        data_rd_i, data_wr_i, data_bitop_i, data_rvalid_o;
  logic        readout_protect_i, ext_rd_i, ext_ready_o, ext_valid_o;
  logic        ext_denied_o, eeprom_req_o, eeprom_wr_o, eeprom_page_o;
  logic        periph_req_o, periph_wr_o, push_i, pop_i;
  logic [12:0] fetch_addr_o, mem_addr_o, ext_addr_i, fa, ma;
  logic [11:0] pc_i, push_data_i, stack_top_o;
  logic [7:0]  data_addr_i, data_wdata_i, data_rdata_o, mem_data_i, d;
  logic [7:0]  ext_data_o, eeprom_wdata_o, eeprom_rdata_i;
  logic [7:0]  periph_addr_o, periph_wdata_o, periph_rdata_i;
  logic [5:0]  eeprom_addr_o;
  logic [2:0]  stack_depth_o;
  int          err_total, n_checks, cyc;
  ppd_row_type rows [8] = '{'{8'h00, 12'h123, 13'h0123},
    '{8'h01, 12'h456, 13'h0c56}, '{8'h01, 12'hc56, 13'h0c56},
    '{8'h02, 12'h7ff, 13'h17ff}, '{8'h03, 12'h000, 13'h1800},
    '{8'h03, 12'hffe, 13'h0ffe}, '{8'hfe, 12'h010, 13'h1010},
    '{8'h02, 12'hffc, 13'h0ffc}};

  ppd_core u_dut (.clk_i, .resetn_i, .ce_i, .fetch_i, .pc_i, .fetch_addr_o,
    .fetch_valid_o, .data_rd_i, .data_wr_i, .data_bitop_i, .data_addr_i,
    .data_wdata_i, .data_rdata_o, .data_rvalid_o, .mem_addr_o, .mem_data_i,
    .readout_protect_i, .ext_rd_i, .ext_addr_i, .ext_ready_o, .ext_data_o,
    .ext_valid_o, .ext_denied_o, .eeprom_req_o, .eeprom_wr_o, .eeprom_page_o,
    .eeprom_addr_o, .eeprom_wdata_o, .eeprom_rdata_i, .periph_req_o,
    .periph_wr_o, .periph_addr_o, .periph_wdata_o, .periph_rdata_i, .push_i,
    .pop_i, .push_data_i, .stack_top_o, .stack_depth_o);
  ppd_mem_model u_mem (.addr_i(mem_addr_o), .data_o(mem_data_i),
    .ee_req_i(eeprom_req_o), .ee_page_i(eeprom_page_o),
    .ee_addr_i(eeprom_addr_o), .ee_data_o(eeprom_rdata_i),
    .pr_req_i(periph_req_o), .pr_addr_i(periph_addr_o),
    .pr_data_o(periph_rdata_i));

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [15:0] ex, got);
    n_checks++;
    if (got !== ex) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, v, input logic bop);
    @(negedge clk_i);
    data_wr_i = 1'b1;
    data_addr_i = a;
    data_wdata_i = v;
    data_bitop_i = bop;
    @(negedge clk_i);
    data_wr_i = 1'b0;
    data_bitop_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk_i);
    data_rd_i = 1'b1;
    data_addr_i = a;
    @(negedge clk_i);
    data_rd_i = 1'b0;
    ma = mem_addr_o;
    @(negedge clk_i);
    chk("rvalid", 16'h1, {15'h0, data_rvalid_o});
    q = data_rdata_o;
  endtask : rd

  task automatic fet(input logic [11:0] pc);
    @(negedge clk_i);
    fetch_i = 1'b1;
    pc_i = pc;
    @(negedge clk_i);
    fetch_i = 1'b0;
    chk("fetch_valid", 16'h1, {15'h0, fetch_valid_o});
    fa = fetch_addr_o;
  endtask : fet

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    {clk_i, resetn_i, fetch_i, data_rd_i, data_wr_i, data_bitop_i} = '0;
    {readout_protect_i, ext_rd_i, push_i, pop_i} = '0;
    {pc_i, push_data_i, ext_addr_i, data_addr_i, data_wdata_i} = '0;
    ce_i = 1'b1;
    repeat (8) @(negedge clk_i);
    resetn_i = 1'b1;
    chk("fetch_valid", 16'h0, {15'h0, fetch_valid_o});
    chk("depth", 16'h0, {13'h0, stack_depth_o});
    $display("test reset done");
    foreach (rows[i]) begin
      wr(PAGE_REG, rows[i].v, 1'b0);
      fet(rows[i].pc);
      chk("fetch", {3'h0, rows[i].ex}, {3'h0, fa});
    end
    $display("test page table done");
    wr(PAGE_REG, 8'h02, 1'b0);
    wr(PAGE_REG, 8'h03, 1'b1);
    fet(12'h000);
    chk("bitop_page", 16'h1000, {3'h0, fa});
    rd(PAGE_REG, d);
    chk("page_read", 16'h0, {8'h0, d});
    for (int i = 0; i < 7; i++) begin
      @(negedge clk_i);
      push_i = 1'b1;
      push_data_i = 12'h100 + 12'(i);
    end
    @(negedge clk_i);
    push_i = 1'b0;
    chk("depth", 16'h6, {13'h0, stack_depth_o});
    chk("top", 16'h106, {4'h0, stack_top_o});
    pop_i = 1'b1;
    @(negedge clk_i);
    pop_i = 1'b0;
    chk("depth", 16'h5, {13'h0, stack_depth_o});
    chk("top", 16'h105, {4'h0, stack_top_o});
    // a push while the clock enable is low must be lost
    ce_i = 1'b0;
    push_i = 1'b1;
    @(negedge clk_i);
    ce_i = 1'b1;
    push_i = 1'b0;
    chk("ce_depth", 16'h5, {13'h0, stack_depth_o});
    chk("ce_top", 16'h105, {4'h0, stack_top_o});
    fet(12'h000);
    chk("page_kept", 16'h1000, {3'h0, fa});
    $display("test page guard done");
    wr(WINDOW_REG, 8'h05, 1'b0);
    rd(8'h47, d);
    chk("win_addr", 16'h0147, {3'h0, ma});
    chk("win_data", 16'h0046, {8'h0, d});
    wr(BANK_REG, BANK_RAM1, 1'b0);
    wr(8'h3a, 8'h5a, 1'b0);
    wr(BANK_REG, BANK_RAM2, 1'b0);
    wr(8'h3a, 8'ha5, 1'b0);
    rd(8'h3a, d);
    chk("ram2", 16'h00a5, {8'h0, d});
    wr(BANK_REG, BANK_RAM1, 1'b0);
    rd(8'h3a, d);
    chk("ram1", 16'h005a, {8'h0, d});
    for (int i = 0; i < 2; i++) begin
      wr(BANK_REG, i ? BANK_EE1 : BANK_EE0, 1'b0);
      rd(8'h05, d);
      chk("eeprom", {8'h0, i ? 8'hc5 : 8'h85}, {8'h0, d});
    end
    // write strobes stand for the cycle after the taking edge
    wr(8'h05, 8'h99, 1'b0);
    chk("ee_wr", 16'h0199, {7'h0, eeprom_wr_o, eeprom_wdata_o});
    wr(8'hd0, 8'h77, 1'b0);
    chk("pr_wr", 16'h0177, {7'h0, periph_wr_o, periph_wdata_o});
    wr(8'h84, 8'h3c, 1'b0);
    rd(8'h84, d);
    chk("gen_ram", 16'h003c, {8'h0, d});
    rd(8'hd0, d);
    chk("periph", 16'h00ec, {8'h0, d});
    $display("test data space done");
    for (int p = 0; p < 2; p++) begin
      @(negedge clk_i);
      readout_protect_i = p[0];
      ext_rd_i = 1'b1;
      ext_addr_i = 13'h0155;
      @(negedge clk_i);
      ext_rd_i = 1'b0;
      @(negedge clk_i);
      chk("ext_valid", 16'h1, {15'h0, ext_valid_o});
      chk("ext_data", p ? 16'h0 : 16'h0054, {8'h0, ext_data_o});
      chk("ext_denied", 16'(p), {15'h0, ext_denied_o});
    end
    $display("test readout done");
    conclude();
  end
endmodule : test_ppd_core
`default_nettype wire
